// *** inc/dcfpc_pkg.sv ***
// constants, load-slot encoding and pin bundles for the fifo port control
// assumes every pin is sampled by one fast core clock
package dcfpc_pkg;
   // ----------------------------------------------------------------
   // geometry
   // ----------------------------------------------------------------
   localparam int DCFPC_DATA_W = 18;
   localparam int DCFPC_DEPTH = 2048;
   localparam int DCFPC_ADDR_W = 11;
   localparam int DCFPC_SYNC_STAGES = 2;

   // ----------------------------------------------------------------
   // control register layout and reset values
   // ----------------------------------------------------------------
   localparam int DCFPC_CTRL_W = 7;
   localparam int DCFPC_CTRL_PAIR_BIT = 6;
   localparam int DCFPC_CTRL_OEGATE_BIT = 5;
   localparam logic [DCFPC_CTRL_W-1:0] DCFPC_CTRL_RESET_ENH = 7'h3f;
   localparam logic [DCFPC_CTRL_W-1:0] DCFPC_CTRL_RESET_COMPAT = 7'h00;
   localparam logic [DCFPC_DATA_W-1:0] DCFPC_OFFSET_RESET = 18'h0007f;

   // ----------------------------------------------------------------
   // load slot sequence, gray ordered
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      DCFPC_LD_EMPTY_OFS = 2'b00,
      DCFPC_LD_FULL_OFS = 2'b01,
      DCFPC_LD_CTRL = 2'b11
   } dcfpc_load_sel_t;

   // ----------------------------------------------------------------
   // pin bundles
   // ----------------------------------------------------------------
   typedef struct packed {
      logic clk;
      logic en_n;
      logic en2;
      logic load_n;
      logic [DCFPC_DATA_W-1:0] word;
   } dcfpc_wr_pins_t;

   typedef struct packed {
      logic clk;
      logic en_n;
      logic en2;
      logic load_n;
      logic oe_n;
      logic enh_n;
   } dcfpc_rd_pins_t;

   // idle pin levels: clock high so release gives no false edge
   localparam dcfpc_wr_pins_t DCFPC_WR_IDLE = '{clk: 1'b1, en_n: 1'b1, en2: 1'b0,
      load_n: 1'b1, word: '0};
   localparam dcfpc_rd_pins_t DCFPC_RD_IDLE = '{clk: 1'b1, en_n: 1'b1, en2: 1'b0,
      load_n: 1'b1, oe_n: 1'b1, enh_n: 1'b1};
endpackage

// *** rtl/dcfpc_sync.sv ***
// two-flop synchroniser for a bundle of pins
// assumes rst_n is already a released copy in the clock domain
`timescale 1ns/1ps
`default_nettype none
module dcfpc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clock,
   input wire logic clock_en,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= RST_VAL;
         q <= RST_VAL;
      end else if (clock_en) begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// *** rtl/dcfpc_top.sv ***
// port control of an 18-bit fifo with independent write and read ports
// assumes port clocks are slow pins sampled by the fast core clock
// Summary of operation
// - write-clock rise, enable low, load high: store input word at next location
// - write enable high: memory and write pointer untouched
// - full flag low: write requests ignored, pointer holds
// - pairing bit set in enhanced mode: write enable is both enables anded
// - read-clock rise, enable low, load high: next word to output register
// - read enable high or empty: output register holds its word
// - pairing bit set in enhanced mode: second read enable anded in
// - gate bit set in enhanced mode: output enable also gates reads
// - data outputs driven while output enable low, released otherwise
// - load low with write: word goes to offset or control register
// - load low with read: offset or control word goes to outputs
// - compatible strap: control register hidden and held at zero
// - full flag low while fifo holds its maximum, updated on write edges
// - empty flag low while fifo holds nothing, updated on read edges
`timescale 1ns/1ps
`default_nettype none
module dcfpc_top
   import dcfpc_pkg::*;
#(
   parameter int DEPTH = DCFPC_DEPTH,
   parameter int ADDR_W = DCFPC_ADDR_W
) (
   input wire logic clock,
   input wire logic clock_en,
   input wire logic rst_n,
   input wire logic write_clock,
   input wire logic write_enable_n,
   input wire logic second_write_enable,
   input wire logic load_select_n,
   input wire logic [DCFPC_DATA_W-1:0] input_word,
   input wire logic read_clock,
   input wire logic read_enable_n,
   input wire logic second_read_enable,
   input wire logic output_enable_n,
   input wire logic enhanced_select_n,
   output logic [DCFPC_DATA_W-1:0] output_word,
   output logic output_word_oe,
   output logic full_flag_n,
   output logic empty_flag_n
);
   // ----------------------------------------------------------------
   // reset release and pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] rst_pipe_reg;
   logic rst_n_q;
   dcfpc_wr_pins_t wr_raw, wr_s;
   dcfpc_rd_pins_t rd_raw, rd_s;
   logic wclk_d_reg, rclk_d_reg;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_pipe_reg <= 2'h0;
      end else if (clock_en) begin
         rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
      end
   end
   assign rst_n_q = rst_pipe_reg[1];

   assign wr_raw = '{clk: write_clock, en_n: write_enable_n, en2: second_write_enable,
      load_n: load_select_n, word: input_word};
   assign rd_raw = '{clk: read_clock, en_n: read_enable_n, en2: second_read_enable,
      load_n: load_select_n, oe_n: output_enable_n, enh_n: enhanced_select_n};

   // load select is shared, so it rides in both bundles to stay aligned with each clock
   dcfpc_sync #(.W($bits(dcfpc_wr_pins_t)), .RST_VAL(DCFPC_WR_IDLE)) u_wr_sync (
      .clock(clock), .clock_en(clock_en), .rst_n(rst_n_q), .d(wr_raw), .q(wr_s));
   dcfpc_sync #(.W($bits(dcfpc_rd_pins_t)), .RST_VAL(DCFPC_RD_IDLE)) u_rd_sync (
      .clock(clock), .clock_en(clock_en), .rst_n(rst_n_q), .d(rd_raw), .q(rd_s));

   always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
         wclk_d_reg <= 1'b1;
         rclk_d_reg <= 1'b1;
      end else if (clock_en) begin
         wclk_d_reg <= wr_s.clk;
         rclk_d_reg <= rd_s.clk;
      end
   end

   // ----------------------------------------------------------------
   // mode and effective enables
   // ----------------------------------------------------------------
   logic [1:0] init_cnt_reg;
   logic ready;
   logic enh_mode;
   logic [DCFPC_CTRL_W-1:0] ctrl_reg;
   logic pair_on, oegate_on;
   logic wr_rise, rd_rise, wr_go, rd_go;
   logic wr_fifo, wr_load, rd_fifo, rd_load;

   // strap is only trusted once the synchroniser has refilled after reset
   assign ready = (init_cnt_reg >= 2'(DCFPC_SYNC_STAGES));
   assign enh_mode = !rd_s.enh_n;
   assign pair_on = enh_mode && ctrl_reg[DCFPC_CTRL_PAIR_BIT];
   assign oegate_on = enh_mode && ctrl_reg[DCFPC_CTRL_OEGATE_BIT];
   assign wr_rise = ready && wr_s.clk && !wclk_d_reg;
   assign rd_rise = ready && rd_s.clk && !rclk_d_reg;
   // second enables are active high, primaries active low
   assign wr_go = !wr_s.en_n && (!pair_on || wr_s.en2);
   assign rd_go = !rd_s.en_n && (!pair_on || rd_s.en2) && (!oegate_on || !rd_s.oe_n);
   assign wr_fifo = clock_en && wr_rise && wr_go && wr_s.load_n && full_flag_n;
   assign wr_load = clock_en && wr_rise && wr_go && !wr_s.load_n;
   assign rd_fifo = clock_en && rd_rise && rd_go && rd_s.load_n && empty_flag_n;
   assign rd_load = clock_en && rd_rise && rd_go && !rd_s.load_n;

   // ----------------------------------------------------------------
   // pointers, memory and flags
   // ----------------------------------------------------------------
   function automatic logic [ADDR_W:0] to_gray(input logic [ADDR_W:0] b);
      to_gray = b ^ (b >> 1);
   endfunction

   logic [DCFPC_DATA_W-1:0] mem [DEPTH];
   logic [ADDR_W:0] wr_ptr_reg, rd_ptr_reg, wr_ptr_next, rd_ptr_next;
   logic [ADDR_W:0] wr_gray_next, rd_gray_next, count;
   logic [DCFPC_DATA_W-1:0] rd_data;
   logic full_now, empty_now;

   assign wr_ptr_next = wr_fifo ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
   assign rd_ptr_next = rd_fifo ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
   assign wr_gray_next = to_gray(wr_ptr_next);
   assign rd_gray_next = to_gray(rd_ptr_next);
   // full when the top two gray bits differ and the rest match
   assign full_now = (wr_gray_next == {~rd_gray_next[ADDR_W:ADDR_W-1],
      rd_gray_next[ADDR_W-2:0]});
   assign empty_now = (wr_gray_next == rd_gray_next);
   assign rd_data = mem[rd_ptr_reg[ADDR_W-1:0]];
   assign count = wr_ptr_reg - rd_ptr_reg;

   always_ff @(posedge clock) begin
      if (wr_fifo) begin
         mem[wr_ptr_reg[ADDR_W-1:0]] <= wr_s.word;
      end
   end

   // flags move only on their own port edge; a stale flag is always the safe one
   always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         full_flag_n <= 1'b1;
         empty_flag_n <= 1'b0;
      end else if (clock_en) begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         if (wr_rise) begin
            full_flag_n <= !full_now;
         end
         if (rd_rise) begin
            empty_flag_n <= !empty_now;
         end
      end
   end

   // ----------------------------------------------------------------
   // offset and control registers
   // ----------------------------------------------------------------
   dcfpc_load_sel_t wr_slot_reg, rd_slot_reg;
   logic [DCFPC_DATA_W-1:0] empty_ofs_reg, full_ofs_reg, load_word;

   function automatic dcfpc_load_sel_t slot_step(input dcfpc_load_sel_t s, input logic enh);
      case (s)
         DCFPC_LD_EMPTY_OFS: slot_step = DCFPC_LD_FULL_OFS;
         DCFPC_LD_FULL_OFS: slot_step = enh ? DCFPC_LD_CTRL : DCFPC_LD_EMPTY_OFS;
         default: slot_step = DCFPC_LD_EMPTY_OFS;
      endcase
   endfunction

   always_comb begin
      case (rd_slot_reg)
         DCFPC_LD_EMPTY_OFS: load_word = empty_ofs_reg;
         DCFPC_LD_FULL_OFS: load_word = full_ofs_reg;
         DCFPC_LD_CTRL: load_word = DCFPC_DATA_W'(ctrl_reg);
         default: load_word = '0;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
         init_cnt_reg <= 2'h0;
         ctrl_reg <= DCFPC_CTRL_RESET_COMPAT;
         empty_ofs_reg <= DCFPC_OFFSET_RESET;
         full_ofs_reg <= DCFPC_OFFSET_RESET;
         wr_slot_reg <= DCFPC_LD_EMPTY_OFS;
         rd_slot_reg <= DCFPC_LD_EMPTY_OFS;
      end else if (clock_en) begin
         // counting one past ready leaves a single edge, at the ready count, that loads the enhanced default
         if (init_cnt_reg != 2'(DCFPC_SYNC_STAGES + 1)) begin
            init_cnt_reg <= init_cnt_reg + 2'h1;
         end
         if (!enh_mode) begin
            ctrl_reg <= DCFPC_CTRL_RESET_COMPAT;
         end else if (init_cnt_reg == 2'(DCFPC_SYNC_STAGES)) begin
            // the strap copy is only settled from the first ready edge
            ctrl_reg <= DCFPC_CTRL_RESET_ENH;
         end else if (wr_load && wr_slot_reg == DCFPC_LD_CTRL) begin
            ctrl_reg <= wr_s.word[DCFPC_CTRL_W-1:0];
         end
         if (wr_load) begin
            if (wr_slot_reg == DCFPC_LD_EMPTY_OFS) begin
               empty_ofs_reg <= wr_s.word;
            end
            if (wr_slot_reg == DCFPC_LD_FULL_OFS) begin
               full_ofs_reg <= wr_s.word;
            end
            wr_slot_reg <= slot_step(wr_slot_reg, enh_mode);
         end
         if (rd_load) begin
            rd_slot_reg <= slot_step(rd_slot_reg, enh_mode);
         end
      end
   end

   // ----------------------------------------------------------------
   // output register and drivers
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
         output_word <= '0;
         output_word_oe <= 1'b0;
      end else if (clock_en) begin
         output_word_oe <= !rd_s.oe_n;
         if (rd_fifo) begin
            output_word <= rd_data;
         end else if (rd_load) begin
            output_word <= load_word;
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n_q);

   chk_write_advance: assert property (wr_fifo |=> wr_ptr_reg == $past(wr_ptr_reg) + 1'b1)
      else $error("write did not advance pointer");
   chk_write_hold: assert property (clock_en && wr_rise && wr_s.en_n |=> $stable(wr_ptr_reg))
      else $error("pointer moved with write enable high");
   chk_full_block: assert property (clock_en && wr_rise && !full_flag_n |=> $stable(wr_ptr_reg))
      else $error("write taken while full");
   chk_pair_write: assert property (clock_en && wr_rise && pair_on && !wr_s.en2
      |=> $stable(wr_ptr_reg))
      else $error("write taken without second enable");
   chk_read_load: assert property (rd_fifo |=> output_word == $past(rd_data))
      else $error("output register missed fifo word");
   chk_read_hold: assert property (clock_en && rd_rise && rd_s.load_n
      && (rd_s.en_n || !empty_flag_n) |=> $stable(output_word))
      else $error("output register changed on blocked read");
   chk_pair_read: assert property (clock_en && rd_rise && pair_on && !rd_s.en2
      |=> $stable(rd_ptr_reg))
      else $error("read taken without second enable");
   chk_oe_gate: assert property (clock_en && rd_rise && oegate_on && rd_s.oe_n
      |=> $stable(rd_ptr_reg) && $stable(output_word))
      else $error("read taken while outputs disabled");
   chk_drive_follow: assert property (clock_en && $changed(rd_s.oe_n)
      |=> output_word_oe == !$past(rd_s.oe_n))
      else $error("output enable not followed");
   chk_compat_ctrl: assert property (!enh_mode |=> ctrl_reg == DCFPC_CTRL_RESET_COMPAT)
      else $error("control register visible in compatible mode");
   chk_full_flag: assert property (full_flag_n |-> count != (ADDR_W+1)'(DEPTH))
      else $error("full flag high while fifo full");
   chk_empty_flag: assert property (empty_flag_n |-> count != '0)
      else $error("empty flag high while fifo empty");
endmodule
`default_nettype wire

// *** bench/dcfpc_host.sv ***
// host model on both fifo ports: each port clock runs only during a transfer
// assumes one transfer at a time, since the load pin is shared by both ports
`timescale 1ns/1ps
`default_nettype none
module dcfpc_host
   import dcfpc_pkg::*;
(
   output logic write_clock,
   output logic write_enable_n,
   output logic second_write_enable,
   output logic load_select_n,
   output logic [DCFPC_DATA_W-1:0] input_word,
   output logic read_clock,
   output logic read_enable_n,
   output logic second_read_enable
);
   initial begin
      write_clock = 1'b0;
      read_clock = 1'b0;
      write_enable_n = 1'b1;
      read_enable_n = 1'b1;
      second_write_enable = 1'b0;
      second_read_enable = 1'b0;
      load_select_n = 1'b1;
      input_word = '0;
   end
   // ----------------------------------------------------------------
   // one 48 ns link cycle, qualifiers held 23 ns before and 24 ns after the rise
   // ----------------------------------------------------------------
   task automatic cycle(input logic wr, input logic en_n, input logic en2,
         input logic ld_n, input logic [DCFPC_DATA_W-1:0] w);
      #1;
      load_select_n = ld_n;
      input_word = w;
      if (wr) begin
         write_enable_n = en_n;
         second_write_enable = en2;
      end else begin
         read_enable_n = en_n;
         second_read_enable = en2;
      end
      #23;
      if (wr) write_clock = 1'b1;
      else read_clock = 1'b1;
      #24;
      write_clock = 1'b0;
      read_clock = 1'b0;
      // released data flips so a stale word cannot pass for a fresh one
      input_word = ~w;
      write_enable_n = 1'b1;
      read_enable_n = 1'b1;
      load_select_n = 1'b1;
   endtask
endmodule
`default_nettype wire

// *** bench/tb_dual_clock_fifo_port_control.sv ***
// self-checking bench for the fifo port control, with a queue model
// assumes the host model owns every port pin; bench drives strap and output enable
`timescale 1ns/1ps
`default_nettype none
module tb_dual_clock_fifo_port_control
   import dcfpc_pkg::*;
;
   localparam int DEPTH = 16;
   logic clock, clock_en, rst_n, output_enable_n, enhanced_select_n;
   logic write_clock, write_enable_n, second_write_enable, load_select_n;
   logic read_clock, read_enable_n, second_read_enable;
   logic [DCFPC_DATA_W-1:0] input_word, output_word;
   logic output_word_oe, full_flag_n, empty_flag_n;
   int n_errors, n_checks;
   logic [31:0] seed;
   logic [17:0] regs [3];
   logic [17:0] q [$];
   logic [17:0] exp_out;
   logic enh, exp_full_n, exp_empty_n;
   int wslot, rslot;

   dcfpc_top #(.DEPTH(DEPTH), .ADDR_W(4)) u_dut (.clock(clock), .clock_en(clock_en),
      .rst_n(rst_n), .write_clock(write_clock), .write_enable_n(write_enable_n),
      .second_write_enable(second_write_enable), .load_select_n(load_select_n),
      .input_word(input_word), .read_clock(read_clock), .read_enable_n(read_enable_n),
      .second_read_enable(second_read_enable), .output_enable_n(output_enable_n),
      .enhanced_select_n(enhanced_select_n), .output_word(output_word),
      .output_word_oe(output_word_oe), .full_flag_n(full_flag_n),
      .empty_flag_n(empty_flag_n));
   dcfpc_host u_host (.write_clock(write_clock), .write_enable_n(write_enable_n),
      .second_write_enable(second_write_enable), .load_select_n(load_select_n),
      .input_word(input_word), .read_clock(read_clock), .read_enable_n(read_enable_n),
      .second_read_enable(second_read_enable));

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic int nxt(input int s);
      if (enh) return (s == 2) ? 0 : s + 1;
      return (s == 1) ? 0 : 1;
   endfunction
   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic do_reset(input logic enh_n);
      @(posedge clock);
      rst_n <= 1'b0;
      enhanced_select_n <= enh_n;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      repeat (10) @(posedge clock);
      enh = !enh_n;
      q.delete();
      regs[0] = DCFPC_OFFSET_RESET;
      regs[1] = DCFPC_OFFSET_RESET;
      regs[2] = enh_n ? 18'h0 : 18'(DCFPC_CTRL_RESET_ENH);
      wslot = 0;
      rslot = 0;
      exp_out = '0;
      exp_full_n = 1'b1;
      exp_empty_n = 1'b0;
      @(negedge clock);
      check(output_word, exp_out);
      check({16'h0, full_flag_n, empty_flag_n}, 18'h2);
   endtask
   task automatic set_oe(input logic v);
      @(posedge clock);
      output_enable_n <= v;
      repeat (5) @(posedge clock);
      @(negedge clock);
   endtask
   // ----------------------------------------------------------------
   // port transfers, each followed by the model and a comparison
   // ----------------------------------------------------------------
   task automatic wr(input logic en_n, input logic en2, input logic ld_n, input logic [17:0] w);
      logic ok;
      ok = !en_n && (!(enh && regs[2][DCFPC_CTRL_PAIR_BIT]) || en2);
      u_host.cycle(1'b1, en_n, en2, ld_n, w);
      if (ok && !ld_n) begin
         regs[wslot] = (wslot == 2) ? (w & 18'h0007f) : w;
         wslot = nxt(wslot);
      end else if (ok && exp_full_n) q.push_back(w);
      exp_full_n = q.size() != DEPTH;
      @(negedge clock);
      check({17'h0, full_flag_n}, {17'h0, exp_full_n});
   endtask
   task automatic rd(input logic en_n, input logic en2, input logic ld_n);
      logic ok;
      ok = !en_n && (!(enh && regs[2][DCFPC_CTRL_PAIR_BIT]) || en2) &&
         (!(enh && regs[2][DCFPC_CTRL_OEGATE_BIT]) || !output_enable_n);
      u_host.cycle(1'b0, en_n, en2, ld_n, '0);
      if (ok && !ld_n) begin
         exp_out = regs[rslot];
         rslot = nxt(rslot);
      end else if (ok && exp_empty_n) exp_out = q.pop_front();
      exp_empty_n = q.size() != 0;
      @(negedge clock);
      check(output_word, exp_out);
      check({17'h0, empty_flag_n}, {17'h0, exp_empty_n});
   endtask
   task automatic regs_test(input logic [17:0] c);
      int n;
      n = enh ? 3 : 2;
      // second enables high in enhanced mode so the readback survives pairing
      repeat (n) rd(1'b0, enh, 1'b0);
      for (int k = 0; k < n; k++) wr(1'b0, enh, 1'b0, (k == 2) ? c : 18'(xs() & 32'h3ff));
      repeat (n) rd(1'b0, enh, 1'b0);
   endtask

   initial begin
      #20000;
      n_errors++;
      close_out();
   end
   initial begin
      rst_n = 1'b0;
      clock_en = 1'b1;
      output_enable_n = 1'b0;
      enhanced_select_n = 1'b1;
      n_errors = 0;
      n_checks = 0;
      seed = 32'd90005;
      do_reset(1'b1);
      // compatible mode: fill past full with one held-off write, then drain
      for (int i = 0; i <= DEPTH; i++) begin
         wr(1'b0, 1'b0, 1'b1, 18'(xs()));
         if (i == 3) wr(1'b1, 1'b0, 1'b1, 18'(xs()));
      end
      rd(1'b1, 1'b0, 1'b1);
      for (int i = 0; i <= DEPTH; i++) begin
         rd(1'b0, 1'b0, 1'b1);
         if (i == 3) rd(1'b1, 1'b0, 1'b1);
      end
      set_oe(1'b1);
      check({17'h0, output_word_oe}, 18'h0);
      set_oe(1'b0);
      check({17'h0, output_word_oe}, 18'h1);
      regs_test(18'h0);
      // enhanced mode: control word sets pairing and output-enable gating
      do_reset(1'b0);
      regs_test(18'h3ff7f);
      wr(1'b0, 1'b0, 1'b1, 18'(xs()));
      wr(1'b0, 1'b1, 1'b1, 18'(xs()));
      wr(1'b0, 1'b1, 1'b1, 18'(xs()));
      rd(1'b1, 1'b1, 1'b1);
      rd(1'b0, 1'b0, 1'b1);
      set_oe(1'b1);
      rd(1'b0, 1'b1, 1'b1);
      set_oe(1'b0);
      rd(1'b0, 1'b1, 1'b1);
      rd(1'b0, 1'b1, 1'b1);
      close_out();
   end
endmodule
`default_nettype wire
